// ==== core/cidr_pkg.sv ====
/*
  cidr_pkg: constants for the core identification register bank.
  Assumes the bank is addressed by a system-coprocessor read encoding
  (primary register, secondary register, second opcode).
*/
package cidr_pkg;
  // register selection encodings (primary, secondary, opcode2)
  localparam logic [3:0] CRN_ID           = 4'h0;
  localparam logic [3:0] CRM_IDENT        = 4'h0;
  localparam logic [3:0] CRM_FEATURE      = 4'h1;
  localparam logic [2:0] OP2_AFFINITY     = 3'h5;
  localparam logic [2:0] OP2_REVISION     = 3'h6;
  localparam logic [2:0] OP2_FEATURE_0    = 3'h0;
  localparam logic [2:0] OP2_FEATURE_1    = 3'h1;
  localparam logic [1:0] OPC1_ID          = 2'h0;

  // affinity register fields
  localparam int         AFF_MP_FORMAT_BIT = 31;
  localparam int         AFF_UNIPROC_BIT   = 30;
  localparam int         AFF_MT_BIT        = 24;
  localparam int         AFF_CLUSTER_LSB   = 8;
  localparam int         AFF_CORE_LSB      = 0;
  localparam logic       AFF_MP_FORMAT     = 1'b1;
  localparam logic       AFF_UNIPROC       = 1'b0;
  localparam logic       AFF_MT            = 1'b0;

  // feature register 0 fields
  localparam logic [3:0] PF0_EXEC_ENV      = 4'h1;
  localparam logic [3:0] PF0_BYTECODE      = 4'h1;
  localparam logic [3:0] PF0_COMPACT       = 4'h3;
  localparam logic [3:0] PF0_FIXED_WIDTH   = 4'h1;
  localparam logic [31:0] PF0_VALUE = {16'h0000, PF0_EXEC_ENV, PF0_BYTECODE, PF0_COMPACT, PF0_FIXED_WIDTH};

  // feature register 1 fields
  localparam logic [3:0] PF1_GEN_TIMER     = 4'h1;
  localparam logic [3:0] PF1_VIRT          = 4'h1;
  localparam logic [3:0] PF1_MCU_MODEL     = 4'h0;
  localparam logic [3:0] PF1_SECURITY      = 4'h1;
  localparam logic [3:0] PF1_PROG_MODEL    = 4'h1;
  localparam logic [31:0] PF1_VALUE = {12'h000, PF1_GEN_TIMER, PF1_VIRT, PF1_MCU_MODEL, PF1_SECURITY, PF1_PROG_MODEL};

  // privilege levels: user is level zero
  localparam logic [1:0] PRIV_LEVEL_ONE    = 2'h1;

  // defaults
  localparam logic [31:0] REVISION_DEFAULT = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO        = 32'h0000_0000;
endpackage

// ==== core/cidr_affinity.sv ====
/*
  cidr_affinity: builds the affinity word from the cluster number and
  core index. Assumes both inputs are already synchronised and stable.
*/
`timescale 1ns/1ps
`default_nettype none
module cidr_affinity #(
  parameter int CORE_BITS = 2
) (
  // identity inputs
  input  wire logic [3:0]           i_cluster,
  input  wire logic [CORE_BITS-1:0] i_core_index,
  // affinity word
  output var  logic [31:0]          o_affinity
);
  // elaboration check: only a one- or two-bit core index fits bits 1..0
  if (CORE_BITS < 1 || CORE_BITS > 2) begin : gen_bad_core_bits
    $error("core index width must be 1 or 2");
  end

  // all reserved fields tie to zero
  always_comb begin
    o_affinity = cidr_pkg::READ_ZERO;
    o_affinity[cidr_pkg::AFF_MP_FORMAT_BIT] = cidr_pkg::AFF_MP_FORMAT;
    o_affinity[cidr_pkg::AFF_UNIPROC_BIT]   = cidr_pkg::AFF_UNIPROC;
    o_affinity[cidr_pkg::AFF_MT_BIT]        = cidr_pkg::AFF_MT;
    o_affinity[cidr_pkg::AFF_CLUSTER_LSB +: 4] = i_cluster;
    o_affinity[cidr_pkg::AFF_CORE_LSB +: CORE_BITS] = i_core_index;
  end
endmodule
`default_nettype wire

// ==== core/cidr_bank.sv ====
/*
  cidr_bank: read-only identification and feature register bank of a core.
  Assumes the pipeline presents one coprocessor read per cycle as a pulse
  with its encoding and the current privilege level; the answer comes one
  cycle later. Cluster number and core index are static straps.
*/
`timescale 1ns/1ps
`default_nettype none
module cidr_bank #(
  parameter int          CORE_BITS = 2,
  parameter logic [31:0] REVISION  = cidr_pkg::REVISION_DEFAULT // arbitrary, set per implementation
) (
  // clock and reset
  input  wire logic                 i_clock,
  input  wire logic                 i_arst_n,
  // static straps from pins
  input  wire logic [3:0]           i_cluster_number_input,
  input  wire logic [CORE_BITS-1:0] i_core_index,
  // coprocessor access request
  input  wire logic                 i_req_valid,
  input  wire logic                 i_req_write,
  input  wire logic [1:0]           i_req_opc1,
  input  wire logic [3:0]           i_req_crn,
  input  wire logic [3:0]           i_req_crm,
  input  wire logic [2:0]           i_req_opc2,
  input  wire logic [1:0]           i_req_priv,
  // answer
  output logic                      o_rsp_valid,
  output logic [31:0]               o_rsp_data,
  output logic                      o_rsp_hit,
  output logic                      o_rsp_undef
);
  typedef enum logic [1:0] {
    CIDR_IDLE = 2'b01,
    CIDR_ANSW = 2'b10
  } cidr_state_t;

  typedef struct packed {
    logic [1:0]           rst_sync;
    logic [3:0]           clu_meta;
    logic [3:0]           clu;
    logic [CORE_BITS-1:0] core_meta;
    logic [CORE_BITS-1:0] core;
    cidr_state_t          state;
    logic                 valid;
    logic [31:0]          data;
    logic                 hit;
    logic                 undef;
  } cidr_regs_t;

  // power-on value of every state field; the async branch loads only this constant
  localparam cidr_regs_t REGS_RESET = '{
    rst_sync:  2'h0,
    clu_meta:  4'h0,
    clu:       4'h0,
    core_meta: {CORE_BITS{1'b0}},
    core:      {CORE_BITS{1'b0}},
    state:     CIDR_IDLE,
    valid:     1'b0,
    data:      cidr_pkg::READ_ZERO,
    hit:       1'b0,
    undef:     1'b0
  };

  cidr_regs_t  r_q;
  cidr_regs_t  r_d;
  logic        rst_n;
  logic [31:0] affinity;
  logic        sel_id;
  logic        sel_feat;
  logic        known;
  logic        priv_ok;
  logic [31:0] rd_word;

  // elaboration check: only a one- or two-bit core index fits the affinity word
  if (CORE_BITS < 1 || CORE_BITS > 2) begin : gen_bad_core_bits
    $error("core index width must be 1 or 2");
  end

  // reset release through two flops of the state struct; the rest of the
  // logic only sees this copy, so release always lands clean on the clock
  assign rst_n = r_q.rst_sync[1];

  cidr_affinity #(
    .CORE_BITS (CORE_BITS)
  ) cidr_affinity_inst (
    .i_cluster    (r_q.clu),
    .i_core_index (r_q.core),
    .o_affinity   (affinity)
  );

  // decode the coprocessor encoding
  always_comb begin
    sel_id   = (i_req_opc1 == cidr_pkg::OPC1_ID) && (i_req_crn == cidr_pkg::CRN_ID);
    sel_feat = sel_id && (i_req_crm == cidr_pkg::CRM_FEATURE);
    sel_id   = sel_id && (i_req_crm == cidr_pkg::CRM_IDENT);
    priv_ok  = (i_req_priv >= cidr_pkg::PRIV_LEVEL_ONE);
    known    = 1'b0;
    rd_word  = cidr_pkg::READ_ZERO;
    if (sel_id && i_req_opc2 == cidr_pkg::OP2_AFFINITY) begin
      known   = 1'b1;
      rd_word = affinity;
    end else if (sel_id && i_req_opc2 == cidr_pkg::OP2_REVISION) begin
      known   = 1'b1;
      rd_word = REVISION;
    end else if (sel_feat && i_req_opc2 == cidr_pkg::OP2_FEATURE_0) begin
      known   = 1'b1;
      rd_word = cidr_pkg::PF0_VALUE;
    end else if (sel_feat && i_req_opc2 == cidr_pkg::OP2_FEATURE_1) begin
      known   = 1'b1;
      rd_word = cidr_pkg::PF1_VALUE;
    end
  end

  // next state: sync straps, answer one cycle after each request
  always_comb begin
    r_d          = r_q;
    r_d.rst_sync = {r_q.rst_sync[0], 1'b1};
    r_d.clu_meta = i_cluster_number_input;
    r_d.clu      = r_q.clu_meta;
    r_d.core_meta = i_core_index;
    r_d.core     = r_q.core_meta;
    r_d.valid    = 1'b0;
    r_d.hit      = 1'b0;
    r_d.undef    = 1'b0;
    r_d.data     = cidr_pkg::READ_ZERO;
    r_d.state    = CIDR_IDLE;
    case (r_q.state)
      CIDR_IDLE, CIDR_ANSW: begin
        if (i_req_valid) begin
          r_d.state = CIDR_ANSW;
          r_d.valid = 1'b1;
          // writes and low-privilege reads are refused, nothing stored
          if (known && priv_ok && !i_req_write) begin
            r_d.hit  = 1'b1;
            r_d.data = rd_word;
          end else begin
            r_d.undef = 1'b1;
          end
        end
      end
      default: begin
        r_d.state = CIDR_IDLE;
      end
    endcase
    // until the release has passed both flops everything else stays at reset,
    // so a request held during reset gets no answer before rst_n rises
    if (!rst_n) begin
      r_d          = REGS_RESET;
      r_d.rst_sync = {r_q.rst_sync[0], 1'b1};
    end
  end

  // one register for all state; only the raw pin clears it asynchronously
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r_q <= REGS_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs come straight from the state flops
  assign o_rsp_valid = r_q.valid;
  assign o_rsp_data  = r_q.data;
  assign o_rsp_hit   = r_q.hit;
  assign o_rsp_undef = r_q.undef;

  // checks
  a_mp_format_bit: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_hit && $past(i_req_opc2) == cidr_pkg::OP2_AFFINITY && $past(i_req_crm) == cidr_pkg::CRM_IDENT
    |-> o_rsp_data[31:30] == 2'h2) else $error("affinity format bits wrong");
  a_aff_zero_fields: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_hit && $past(i_req_opc2) == cidr_pkg::OP2_AFFINITY && $past(i_req_crm) == cidr_pkg::CRM_IDENT
    |-> o_rsp_data[29:12] == 18'h00000 && o_rsp_data[7:2] == 6'h00) else $error("affinity reserved not zero");
  a_cluster_field: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_hit && $past(i_req_opc2) == cidr_pkg::OP2_AFFINITY && $past(i_req_crm) == cidr_pkg::CRM_IDENT
    |-> o_rsp_data[11:8] == $past(r_q.clu)) else $error("cluster field wrong");
  a_core_field: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_hit && $past(i_req_opc2) == cidr_pkg::OP2_AFFINITY && $past(i_req_crm) == cidr_pkg::CRM_IDENT
    |-> o_rsp_data[CORE_BITS-1:0] == $past(r_q.core)) else $error("core field wrong");
  a_low_priv_refused: assert property (@(posedge i_clock) disable iff (!rst_n)
    i_req_valid && i_req_priv == 2'h0 |=> o_rsp_undef && !o_rsp_hit) else $error("user access not refused");
  a_write_refused: assert property (@(posedge i_clock) disable iff (!rst_n)
    i_req_valid && i_req_write |=> o_rsp_undef && o_rsp_data == 32'h0000_0000) else $error("write accepted");
  a_revision_read: assert property (@(posedge i_clock) disable iff (!rst_n)
    i_req_valid && !i_req_write && i_req_priv != 2'h0 && i_req_opc1 == 2'h0 && i_req_crn == 4'h0
    && i_req_crm == 4'h0 && i_req_opc2 == 3'h6 |=> o_rsp_hit && o_rsp_data == REVISION) else $error("revision wrong");
  a_feature0_read: assert property (@(posedge i_clock) disable iff (!rst_n)
    i_req_valid && !i_req_write && i_req_priv != 2'h0 && i_req_opc1 == 2'h0 && i_req_crn == 4'h0
    && i_req_crm == 4'h1 && i_req_opc2 == 3'h0 |=> o_rsp_data == 32'h0000_1131) else $error("feature 0 wrong");
  a_feature1_read: assert property (@(posedge i_clock) disable iff (!rst_n)
    i_req_valid && !i_req_write && i_req_priv != 2'h0 && i_req_opc1 == 2'h0 && i_req_crn == 4'h0
    && i_req_crm == 4'h1 && i_req_opc2 == 3'h1 |=> o_rsp_data == 32'h0001_1011) else $error("feature 1 wrong");
  a_one_cycle_answer: assert property (@(posedge i_clock) disable iff (!rst_n)
    i_req_valid |=> o_rsp_valid ##1 (o_rsp_valid == $past(i_req_valid))) else $error("answer timing wrong");

  // affinity word, checked in the cycle its answer stands, and the strap flops it reads, checked every cycle
  a_aff_mt_zero: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_hit && $past(i_req_opc2) == cidr_pkg::OP2_AFFINITY && $past(i_req_crm) == cidr_pkg::CRM_IDENT
    |-> o_rsp_data[24:12] == 13'h0000)
    else $error("affinity multithread field not zero");
  a_cluster_sync: assert property (@(posedge i_clock) disable iff (!rst_n)
    // the affinity word only ever reads the second flop
    r_q.clu == $past(r_q.clu_meta))
    else $error("cluster strap skipped a flop");
  a_core_sync: assert property (@(posedge i_clock) disable iff (!rst_n)
    // same two-flop path for the core index strap
    r_q.core == $past(r_q.core_meta))
    else $error("core index strap skipped a flop");
  a_aff_read_hit: assert property (@(posedge i_clock) disable iff (!rst_n)
    i_req_valid && !i_req_write && i_req_priv != 2'h0 && i_req_opc1 == 2'h0 && i_req_crn == 4'h0
    && i_req_crm == 4'h0 && i_req_opc2 == 3'h5
    |=> o_rsp_hit && o_rsp_data[31] == 1'b1) else $error("affinity read not served");

  // feature words: one field per check, the top field with the reserved bits above it, so a failure names the field
  a_exec_env_field: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_hit && $past(i_req_crm) == cidr_pkg::CRM_FEATURE && $past(i_req_opc2) == cidr_pkg::OP2_FEATURE_0
    |-> o_rsp_data[31:12] == 20'h00001)
    else $error("feature 0 exec env field wrong");
  a_bytecode_field: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_hit && $past(i_req_crm) == cidr_pkg::CRM_FEATURE && $past(i_req_opc2) == cidr_pkg::OP2_FEATURE_0
    |-> o_rsp_data[11:8] == 4'h1)
    else $error("feature 0 bytecode field wrong");
  a_compact_field: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_hit && $past(i_req_crm) == cidr_pkg::CRM_FEATURE && $past(i_req_opc2) == cidr_pkg::OP2_FEATURE_0
    |-> o_rsp_data[7:4] == 4'h3)
    else $error("feature 0 compact field wrong");
  a_fixed_width_field: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_hit && $past(i_req_crm) == cidr_pkg::CRM_FEATURE && $past(i_req_opc2) == cidr_pkg::OP2_FEATURE_0
    |-> o_rsp_data[3:0] == 4'h1)
    else $error("feature 0 fixed width field wrong");
  a_gen_timer_field: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_hit && $past(i_req_crm) == cidr_pkg::CRM_FEATURE && $past(i_req_opc2) == cidr_pkg::OP2_FEATURE_1
    |-> o_rsp_data[31:16] == 16'h0001)
    else $error("feature 1 timer field wrong");
  a_virt_field: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_hit && $past(i_req_crm) == cidr_pkg::CRM_FEATURE && $past(i_req_opc2) == cidr_pkg::OP2_FEATURE_1
    |-> o_rsp_data[15:12] == 4'h1)
    else $error("feature 1 virtualization field wrong");
  a_mcu_model_field: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_hit && $past(i_req_crm) == cidr_pkg::CRM_FEATURE && $past(i_req_opc2) == cidr_pkg::OP2_FEATURE_1
    |-> o_rsp_data[11:8] == 4'h0)
    else $error("feature 1 microcontroller field wrong");
  a_security_field: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_hit && $past(i_req_crm) == cidr_pkg::CRM_FEATURE && $past(i_req_opc2) == cidr_pkg::OP2_FEATURE_1
    |-> o_rsp_data[7:4] == 4'h1)
    else $error("feature 1 security field wrong");
  a_prog_model_field: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_hit && $past(i_req_crm) == cidr_pkg::CRM_FEATURE && $past(i_req_opc2) == cidr_pkg::OP2_FEATURE_1
    |-> o_rsp_data[3:0] == 4'h1)
    else $error("feature 1 programmers model field wrong");

  // answer shape and refusals
  a_hit_excludes_undef: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_valid
    |-> o_rsp_hit != o_rsp_undef)
    else $error("answer both served and refused");
  a_no_answer_flags: assert property (@(posedge i_clock) disable iff (!rst_n)
    !o_rsp_valid
    |-> !o_rsp_hit && !o_rsp_undef && o_rsp_data == 32'h0000_0000)
    else $error("flags or data without an answer");
  a_refused_data_zero: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_undef
    |-> o_rsp_data == 32'h0000_0000)
    else $error("refused answer carries data");
  a_idle_quiet: assert property (@(posedge i_clock) disable iff (!rst_n)
    !i_req_valid
    |=> !o_rsp_valid)
    else $error("answer without a request");
  a_answer_has_request: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_valid
    |-> $past(i_req_valid))
    else $error("answer not one cycle after request");
  a_opc1_refused: assert property (@(posedge i_clock) disable iff (!rst_n)
    i_req_valid && i_req_opc1 != 2'h0
    |=> o_rsp_undef && !o_rsp_hit)
    else $error("foreign first opcode served");
  a_crn_refused: assert property (@(posedge i_clock) disable iff (!rst_n)
    i_req_valid && i_req_crn != 4'h0
    |=> o_rsp_undef && !o_rsp_hit)
    else $error("foreign primary register served");
  a_crm_refused: assert property (@(posedge i_clock) disable iff (!rst_n)
    i_req_valid && i_req_crm > 4'h1
    |=> o_rsp_undef && !o_rsp_hit)
    else $error("foreign secondary register served");
  a_feat_opc2_refused: assert property (@(posedge i_clock) disable iff (!rst_n)
    i_req_valid && i_req_crm == 4'h1 && i_req_opc2 > 3'h1
    |=> o_rsp_undef && !o_rsp_hit)
    else $error("unbuilt feature register served");
  a_ident_opc2_refused: assert property (@(posedge i_clock) disable iff (!rst_n)
    i_req_valid && i_req_crm == 4'h0 && i_req_opc2 != 3'h5 && i_req_opc2 != 3'h6
    |=> o_rsp_undef && !o_rsp_hit)
    else $error("unbuilt identification register served");
  a_write_no_hit: assert property (@(posedge i_clock) disable iff (!rst_n)
    i_req_valid && i_req_write
    |=> !o_rsp_hit)
    else $error("write reported as served");
  a_user_no_data: assert property (@(posedge i_clock) disable iff (!rst_n)
    i_req_valid && i_req_priv == 2'h0
    |=> o_rsp_data == 32'h0000_0000)
    else $error("user level saw register data");
  a_hit_needs_priv: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_hit
    |-> $past(i_req_priv) != 2'h0)
    else $error("served without privilege");
  a_state_onehot: assert property (@(posedge i_clock) disable iff (!rst_n)
    // a corrupted state code would fall to the default branch and drop answers
    $onehot(r_q.state))
    else $error("state code not one-hot");

  // no answer may escape while the synchroniser still holds reset
  a_quiet_in_reset: assert property (@(posedge i_clock)
    !rst_n
    |-> !o_rsp_valid && !o_rsp_hit && !o_rsp_undef)
    else $error("answer while reset held");

  // scenarios worth seeing in a run
  c_aff_read: cover property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_hit && o_rsp_data[31]);
  c_refused: cover property (@(posedge i_clock) disable iff (!rst_n) o_rsp_undef);
  c_back_to_back: cover property (@(posedge i_clock) disable iff (!rst_n) o_rsp_hit [*2]);
  c_feature1_read: cover property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_hit && $past(i_req_crm) == cidr_pkg::CRM_FEATURE && $past(i_req_opc2) == cidr_pkg::OP2_FEATURE_1);
  c_write_refused: cover property (@(posedge i_clock) disable iff (!rst_n)
    o_rsp_undef && $past(i_req_write));
endmodule
`default_nettype wire

// ==== test/cidr_bank_bench.sv ====
/*
  cidr_bank_bench: self-checking bench for the identification register bank.
  Assumes the bank's one-cycle request/answer contract; the bench drives the
  straps and the request port itself, with no other bus in between.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin fail_count++; \
  $display("[FAIL] t=%0t act=%0h exp=%0h", $time, (act), (exp)); end end
module cidr_bank_bench;
  localparam int          CORE_BITS = 2;
  localparam logic [31:0] REV_VALUE = 32'h5A3C_96E1;                          // arbitrary revision value
  localparam logic [31:0] FEAT0     = {16'h0000, 4'h1, 4'h1, 4'h3, 4'h1};
  localparam logic [31:0] FEAT1     = {12'h000, 4'h1, 4'h1, 4'h0, 4'h1, 4'h1};
  // one queued request with its expected answer
  typedef struct packed {
    logic        wr;
    logic [1:0]  opc1;
    logic [3:0]  crn;
    logic [3:0]  crm;
    logic [2:0]  opc2;
    logic [1:0]  priv;
    logic        hit;
    logic [31:0] data;
  } cidr_req_t;
  logic                 i_clock;
  logic                 i_arst_n;
  logic [3:0]           i_cluster_number_input;
  logic [CORE_BITS-1:0] i_core_index;
  logic                 i_req_valid;
  logic                 i_req_write;
  logic [1:0]           i_req_opc1;
  logic [3:0]           i_req_crn;
  logic [3:0]           i_req_crm;
  logic [2:0]           i_req_opc2;
  logic [1:0]           i_req_priv;
  logic                 o_rsp_valid;
  logic [31:0]          o_rsp_data;
  logic                 o_rsp_hit;
  logic                 o_rsp_undef;
  int                   fail_count = 0;
  int                   checks     = 0;
  int                   i;
  cidr_req_t            reqs[$];

  cidr_bank #(.CORE_BITS(CORE_BITS), .REVISION(REV_VALUE)) cidr_bank_inst (
    .i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_cluster_number_input(i_cluster_number_input), .i_core_index(i_core_index),
    .i_req_valid(i_req_valid), .i_req_write(i_req_write), .i_req_opc1(i_req_opc1),
    .i_req_crn(i_req_crn), .i_req_crm(i_req_crm), .i_req_opc2(i_req_opc2), .i_req_priv(i_req_priv),
    .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data), .o_rsp_hit(o_rsp_hit), .o_rsp_undef(o_rsp_undef)
  );

  // 20 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  // expected affinity word: only cluster and core index vary
  function automatic logic [31:0] aff(input logic [3:0] cl, input logic [1:0] co);
    return {1'b1, 1'b0, 5'h00, 1'b0, 12'h000, cl, 6'h00, co};
  endfunction

  task automatic add(input logic wr, input logic [1:0] opc1, input logic [3:0] crn, input logic [3:0] crm,
                     input logic [2:0] opc2, input logic [1:0] priv, input logic hit, input logic [31:0] data);
    reqs.push_back('{wr, opc1, crn, crm, opc2, priv, hit, data});
  endtask

  // called at a rising edge: present one request
  task automatic drive(input cidr_req_t r);
    i_req_valid <= 1'b1;
    i_req_write <= r.wr;
    i_req_opc1  <= r.opc1;
    i_req_crn   <= r.crn;
    i_req_crm   <= r.crm;
    i_req_opc2  <= r.opc2;
    i_req_priv  <= r.priv;
  endtask

  // issue the queue back to back; each answer is looked at in its only cycle
  task automatic run_queue;
    int          k;
    logic [34:0] want;
    @(posedge i_clock);
    drive(reqs[0]);
    #1 `CHK({o_rsp_valid, o_rsp_hit, o_rsp_undef, o_rsp_data}, 35'h0)
    for (k = 0; k < reqs.size(); k++) begin
      @(posedge i_clock);
      if (k + 1 < reqs.size()) begin
        drive(reqs[k+1]);
      end else begin
        i_req_valid <= 1'b0;
      end
      // refused answers carry no data and raise only the refusal flag
      want = {1'b1, reqs[k].hit, ~reqs[k].hit, (reqs[k].hit ? reqs[k].data : 32'h0)};
      #1 `CHK({o_rsp_valid, o_rsp_hit, o_rsp_undef, o_rsp_data}, want)
    end
    reqs.delete();
  endtask

  task automatic stop_test;
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge i_clock);
    fail_count++;
    stop_test();
  end

  // main sequence
  initial begin
    i_arst_n = 1'b0;
    i_cluster_number_input = 4'h0;
    i_core_index = 2'h0;
    i_req_valid = 1'b1;
    i_req_write = 1'b0;
    i_req_opc1 = 2'h0;
    i_req_crn = 4'h0;
    i_req_crm = 4'h0;
    i_req_opc2 = 3'h5;
    i_req_priv = 2'h1;
    repeat (8) @(posedge i_clock);
    // a request held during reset must not be answered
    `CHK({o_rsp_valid, o_rsp_hit, o_rsp_undef, o_rsp_data}, 35'h0)
    i_arst_n <= 1'b1;
    i_req_valid <= 1'b0;
    repeat (3) @(posedge i_clock);
    // straps: each change gets two synchroniser edges before it is read
    for (i = 0; i < 4; i++) begin
      @(posedge i_clock);
      i_cluster_number_input <= 4'(i * 5);
      i_core_index <= 2'(i);
      repeat (2) @(posedge i_clock);
      add(1'b0, 2'h0, 4'h0, 4'h0, 3'h5, 2'h1, 1'b1, aff(4'(i * 5), 2'(i)));
      add(1'b0, 2'h0, 4'h0, 4'h0, 3'h5, 2'(i), i != 0, aff(4'(i * 5), 2'(i)));
      add(1'b1, 2'h0, 4'h0, 4'h0, 3'h5, 2'h1, 1'b0, 32'h0);
      run_queue();
    end
    // whole bank, writes refused and leaving contents alone, strays refused
    add(1'b0, 2'h0, 4'h0, 4'h0, 3'h6, 2'h1, 1'b1, REV_VALUE);
    add(1'b0, 2'h0, 4'h0, 4'h1, 3'h0, 2'h2, 1'b1, FEAT0);
    add(1'b0, 2'h0, 4'h0, 4'h1, 3'h1, 2'h3, 1'b1, FEAT1);
    add(1'b1, 2'h0, 4'h0, 4'h0, 3'h6, 2'h1, 1'b0, 32'h0);
    add(1'b1, 2'h0, 4'h0, 4'h1, 3'h0, 2'h1, 1'b0, 32'h0);
    add(1'b1, 2'h0, 4'h0, 4'h1, 3'h1, 2'h1, 1'b0, 32'h0);
    add(1'b0, 2'h0, 4'h0, 4'h0, 3'h6, 2'h1, 1'b1, REV_VALUE);
    add(1'b0, 2'h0, 4'h0, 4'h1, 3'h0, 2'h1, 1'b1, FEAT0);
    add(1'b0, 2'h0, 4'h0, 4'h1, 3'h1, 2'h1, 1'b1, FEAT1);
    add(1'b0, 2'h0, 4'h0, 4'h0, 3'h5, 2'h1, 1'b1, aff(4'hF, 2'h3));
    add(1'b0, 2'h1, 4'h0, 4'h0, 3'h5, 2'h1, 1'b0, 32'h0);
    add(1'b0, 2'h0, 4'h1, 4'h0, 3'h5, 2'h1, 1'b0, 32'h0);
    add(1'b0, 2'h0, 4'h0, 4'h1, 3'h2, 2'h1, 1'b0, 32'h0);
    add(1'b0, 2'h0, 4'h0, 4'h0, 3'h0, 2'h1, 1'b0, 32'h0);
    add(1'b0, 2'h0, 4'h0, 4'h1, 3'h0, 2'h0, 1'b0, 32'h0);
    add(1'b0, 2'h0, 4'h0, 4'h0, 3'h6, 2'h0, 1'b0, 32'h0);
    run_queue();
    stop_test();
  end
endmodule
`default_nettype wire
